// file: adc_channel_sequencer.v
// Purpose: sequencer modes 1 to 3 of a multichannel converter
// Assumes: command bytes arrive as one-cycle strobes; conversions by an outside engine
// Notes:   mode 4 and calibration are only recognised, not run
`timescale 1ns/100ps
`include "seq_defs.vh"
module adc_channel_sequencer (
  input  wire        mclk,
  input  wire        rstn,
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_byte,
  input  wire [1:0]  scan_mode,
  input  wire [2:0]  input_select,
  input  wire        settle_delay_enable,
  input  wire        ready_gating,
  input  wire        output_settle_delay_enable,
  input  wire [1:0]  exit_state_select,
  input  wire        single_cycle_flag,
  input  wire        repeat_single_cycle_flag,
  input  wire [23:0] channel_table_low,
  input  wire [23:0] channel_table_high,
  input  wire [5:0]  output_drive_register,
  input  wire [7:0]  mux_delay,
  input  wire [7:0]  output_delay,
  input  wire        conv_done,
  input  wire        ready_clear,
  output reg  [1:0]  power_state_status,
  output reg  [5:0]  channel_ready_flags,
  output reg  [5:0]  general_output_pin,
  output reg         ready_interrupt_pin,
  output reg  [2:0]  mux_channel,
  output reg         conv_start,
  output reg         autoscan_request,
  output reg         calibration_request,
  output reg  [3:0]  conv_rate
);
  localparam ST_IDLE   = 3'h0;
  localparam ST_PICK   = 3'h1;
  localparam ST_OUTDLY = 3'h2;
  localparam ST_MUXDLY = 3'h3;
  localparam ST_CONV   = 3'h4;
  localparam ST_WAIT   = 3'h5;
  reg  [2:0] state_reg;
  reg  [1:0] mode_reg;
  reg        cont_reg;
  reg  [5:0] done_mask_reg;
  reg  [2:0] cur_ch_reg;
  reg        dly_start;
  reg  [7:0] dly_len;
  wire       dly_done;
  // channel c table: order [2:0], enable [3], output map [6:4], output enable [7]
  // tables passed in so that @* blocks see them change
  function [7:0] ch_field;
    input [2:0]  c;
    input [23:0] lo;
    input [23:0] hi;
    begin
      case (c)
        3'h0: ch_field = lo[7:0];
        3'h1: ch_field = lo[15:8];
        3'h2: ch_field = lo[23:16];
        3'h3: ch_field = hi[7:0];
        3'h4: ch_field = hi[15:8];
        default: ch_field = hi[23:16];
      endcase
    end
  endfunction
  // conversion command carrying the given mode field
  function cmd_is;
    input [7:0] b;
    input [1:0] m;
    begin
      cmd_is = (b[7:6] == `CMD_CONV_TAG) && (b[5:4] == m);
    end
  endfunction
  // standby only when chosen, and only from mode 1 continuous or while not active
  function [1:0] exit_code;
    input       m1_continuous;
    input [1:0] sel;
    begin
      if (m1_continuous && sel == `EXIT_STANDBY)
        exit_code = `PWR_STANDBY;
      else
        exit_code = `PWR_SLEEP;
    end
  endfunction
  // one-hot bias output of a channel, none when its output is off
  function [5:0] bias_bits;
    input [7:0] fld;
    begin
      if (fld[7])
        bias_bits = 6'h01 << fld[6:4];
      else
        bias_bits = 6'h00;
    end
  endfunction
  function [7:0] delay_or_none;
    input       en;
    input [7:0] len;
    begin
      delay_or_none = en ? len : 8'h00;
    end
  endfunction
  // pick enabled, unconverted channel with lowest order, lowest index on a tie
  reg  [2:0] best_ch;
  reg        best_ok;
  reg  [2:0] best_ord;
  reg  [7:0] f;
  integer    i;
  always @* begin
    best_ch  = 3'h0;
    best_ok  = 1'b0;
    best_ord = 3'h7;
    f        = 8'h00;
    for (i = 0; i < `NUM_CH; i = i + 1) begin
      f = ch_field(i[2:0], channel_table_low, channel_table_high);
      if (f[3] && !done_mask_reg[i] && (!best_ok || f[2:0] < best_ord)) begin
        best_ok  = 1'b1;
        best_ord = f[2:0];
        best_ch  = i[2:0];
      end
    end
  end
  reg  [5:0] enabled_mask;
  reg  [7:0] g;
  integer    j;
  always @* begin
    enabled_mask = 6'h00;
    g            = 8'h00;
    for (j = 0; j < `NUM_CH; j = j + 1) begin
      g               = ch_field(j[2:0], channel_table_low, channel_table_high);
      enabled_mask[j] = g[3];
    end
  end
  wire       exit_cmd    = cmd_valid && cmd_is(cmd_byte, `CMD_MODE_EXIT);
  wire       run_cmd     = cmd_valid && cmd_is(cmd_byte, `CMD_MODE_RUN);
  wire       cal_cmd     = cmd_valid && cmd_is(cmd_byte, `CMD_MODE_CAL);
  wire       m1_cont     = !single_cycle_flag || repeat_single_cycle_flag;
  wire [7:0] best_field  = ch_field(best_ch, channel_table_low, channel_table_high);
  wire       last_ch     = (done_mask_reg | (6'h01 << cur_ch_reg)) == enabled_mask;
  // autoscan keeps the converter busy although the local walk is idle
  wire       active      = (state_reg != ST_IDLE) || autoscan_request;
  wire [1:0] exit_target = exit_code(mode_reg == `SEQ_MODE1 && cont_reg, exit_state_select);
  delay_timer u_delay (
    .mclk  (mclk),
    .rstn  (rstn),
    .start (dly_start),
    .len   (dly_len),
    .done  (dly_done)
  );
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg           <= ST_IDLE;
      mode_reg            <= `SEQ_MODE1;
      cont_reg            <= 1'b0;
      done_mask_reg       <= 6'h00;
      cur_ch_reg          <= 3'h0;
      dly_start           <= 1'b0;
      dly_len             <= 8'h00;
      power_state_status  <= `PWR_SLEEP;
      channel_ready_flags <= 6'h00;
      general_output_pin  <= 6'h00;
      ready_interrupt_pin <= 1'b0;
      mux_channel         <= 3'h0;
      conv_start          <= 1'b0;
      autoscan_request    <= 1'b0;
      calibration_request <= 1'b0;
      conv_rate           <= 4'h0;
    end else begin
      dly_start           <= 1'b0;
      conv_start          <= 1'b0;
      calibration_request <= 1'b0;
      if (mode_reg != `SEQ_MODE3 || state_reg == ST_IDLE)
        general_output_pin <= output_drive_register;
      // clear first: a result in the same cycle sets again below and wins
      if (ready_clear) begin
        ready_interrupt_pin <= 1'b0;
        channel_ready_flags <= 6'h00;
      end
      // exit wins over everything, even in mid-delay
      if (exit_cmd && active) begin
        state_reg          <= ST_IDLE;
        power_state_status <= exit_target;
        autoscan_request   <= 1'b0;
      end else if (exit_cmd) begin
        power_state_status <= exit_code(1'b1, exit_state_select);
      end else if (cal_cmd) begin
        calibration_request <= 1'b1;
      end else if (run_cmd && !active) begin
        conv_rate          <= cmd_byte[3:0];
        mode_reg           <= scan_mode;
        cont_reg           <= m1_cont && scan_mode == `SEQ_MODE1;
        done_mask_reg      <= 6'h00;
        channel_ready_flags<= 6'h00;
        power_state_status <= `PWR_CONVERTING;
        if (scan_mode == `SEQ_MODE4)
          autoscan_request <= 1'b1;
        else
          state_reg <= ST_PICK;
      end else begin
        case (state_reg)
          ST_IDLE: begin
          end
          // next channel, or sleep when none is left
          ST_PICK: begin
            if (mode_reg == `SEQ_MODE1) begin
              cur_ch_reg <= input_select;
              mux_channel <= input_select;
              dly_start <= 1'b1;
              dly_len   <= delay_or_none(settle_delay_enable, mux_delay);
              state_reg <= ST_MUXDLY;
            end else if (!best_ok) begin
              state_reg          <= ST_IDLE;
              power_state_status <= `PWR_SLEEP;
            end else begin
              cur_ch_reg <= best_ch;
              if (mode_reg == `SEQ_MODE3) begin
                general_output_pin <= bias_bits(best_field);
                dly_start <= 1'b1;
                dly_len   <= delay_or_none(output_settle_delay_enable, output_delay);
                state_reg <= ST_OUTDLY;
              end else begin
                mux_channel <= best_ch;
                dly_start <= 1'b1;
                dly_len   <= delay_or_none(settle_delay_enable, mux_delay);
                state_reg <= ST_MUXDLY;
              end
            end
          end
          // bias settles before the channel is selected
          ST_OUTDLY: begin
            // a late pulse of an aborted delay is ignored while the start is out
            if (dly_done && !dly_start) begin
              mux_channel <= cur_ch_reg;
              dly_start   <= 1'b1;
              dly_len     <= delay_or_none(settle_delay_enable, mux_delay);
              state_reg   <= ST_MUXDLY;
            end
          end
          // input settles before conversion start
          ST_MUXDLY: begin
            if (dly_done && !dly_start) begin
              conv_start <= 1'b1;
              state_reg  <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (conv_done) begin
              channel_ready_flags[cur_ch_reg] <= 1'b1;
              done_mask_reg[cur_ch_reg]       <= 1'b1;
              if (mode_reg == `SEQ_MODE1) begin
                ready_interrupt_pin <= 1'b1;
                if (cont_reg) begin
                  state_reg <= ST_MUXDLY;
                  dly_start <= 1'b1;
                  dly_len   <= 8'h00;
                end else begin
                  state_reg          <= ST_IDLE;
                  power_state_status <= `PWR_SLEEP;
                end
              end else begin
                if (!ready_gating || last_ch)
                  ready_interrupt_pin <= 1'b1;
                if (last_ch) begin
                  state_reg          <= ST_IDLE;
                  power_state_status <= `PWR_SLEEP;
                  if (mode_reg == `SEQ_MODE3)
                    general_output_pin <= 6'h00;
                end else begin
                  state_reg <= ST_PICK;
                end
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // adc_channel_sequencer

// file: conv_engine_model.sv
// Purpose: stand-in for the outside conversion engine
// Assumes: one start per conversion, no overlap
// Notes:   fixed latency; a new start restarts the count
`timescale 1ns/100ps
module conv_engine_model #(parameter LAT = 10) (
  input  wire mclk,
  input  wire rstn,
  input  wire conv_start,
  output reg  conv_done
);
  reg [7:0] cnt_reg;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg   <= 8'h00;
      conv_done <= 1'b0;
    end else begin
      conv_done <= (cnt_reg == 8'h01);
      if (conv_start)
        cnt_reg <= LAT[7:0];
      else if (cnt_reg != 8'h00)
        cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule // conv_engine_model

// file: delay_timer.v
// Purpose: programmable settling delay counter
// Assumes: one tick unit per count of len
// Notes:   len of zero finishes on the next cycle
`timescale 1ns/100ps
`include "seq_defs.vh"
module delay_timer (
  input  wire       mclk,
  input  wire       rstn,
  input  wire       start,
  input  wire [7:0] len,
  output reg        done
);
  reg [7:0]  units_reg;
  reg [15:0] tick_reg;
  reg        busy_reg;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      units_reg <= 8'h00;
      tick_reg  <= 16'h0000;
      busy_reg  <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        units_reg <= len;
        tick_reg  <= 16'h0000;
        busy_reg  <= 1'b1;
      end else if (busy_reg) begin
        if (units_reg == 8'h00) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
        end else if (tick_reg == `DELAY_TICK_LAST) begin
          tick_reg  <= 16'h0000;
          units_reg <= units_reg - 8'h01;
        end else begin
          tick_reg <= tick_reg + 16'h0001;
        end
      end
    end
  end
endmodule // delay_timer

// file: seq_defs.vh
// Purpose: constants for the conversion sequencer
// Assumes: 20 MHz mclk
// Notes:   power state codes as reported to the host
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH
`define CMD_CONV_TAG      2'h2
`define CMD_MODE_UNUSED   2'h0
`define CMD_MODE_EXIT     2'h1
`define CMD_MODE_CAL      2'h2
`define CMD_MODE_RUN      2'h3
`define SEQ_MODE1         2'h0
`define SEQ_MODE2         2'h1
`define SEQ_MODE3         2'h2
`define SEQ_MODE4         2'h3
`define PWR_CONVERTING    2'h0
`define PWR_SLEEP         2'h1
`define PWR_STANDBY       2'h2
`define EXIT_SLEEP        2'h1
`define EXIT_STANDBY      2'h2
`define NUM_CH            6
`define DELAY_TICK_NS     1000
`define CLK_PERIOD_NS     50
`define DELAY_TICK_CYC    ((`DELAY_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// sized last count of one tick, DELAY_TICK_CYC - 1
`define DELAY_TICK_LAST   16'h0013
`endif

// file: seq_sva.sv
// Purpose: port checks for the sequencer
// Assumes: one clock, async low reset
// Notes:   bound to every sequencer instance
`timescale 1ns/100ps
module seq_sva (
  input wire       mclk,
  input wire       rstn,
  input wire       cmd_valid,
  input wire [7:0] cmd_byte,
  input wire [1:0] scan_mode,
  input wire [2:0] input_select,
  input wire       single_cycle_flag,
  input wire [1:0] exit_state_select,
  input wire [5:0] output_drive_register,
  input wire [1:0] power_state_status,
  input wire [5:0] general_output_pin,
  input wire [2:0] mux_channel,
  input wire       conv_start,
  input wire       autoscan_request
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire conv = cmd_valid && cmd_byte[7:6] == 2'b10;
  wire run  = conv && cmd_byte[5:4] == 2'b11;
  wire quit = conv && cmd_byte[5:4] == 2'b01;
  wire idle = power_state_status != 2'h0;
  property p_exit; quit |=> power_state_status inside {2'h1, 2'h2}; endproperty
  a_exit: assert property (p_exit) else $error("exit left no power-down state");
  property p_run; run && idle && scan_mode != 2'h3 |=> power_state_status == 2'h0; endproperty
  a_run: assert property (p_run) else $error("run did not start converting");
  property p_auto; run && idle && scan_mode == 2'h3 |=> autoscan_request; endproperty
  a_auto: assert property (p_auto) else $error("autoscan not requested");
  property p_other; cmd_valid && !conv && idle |=> $stable(power_state_status); endproperty
  a_other: assert property (p_other) else $error("register byte changed state");
  property p_keep;
    quit && !idle && scan_mode == 2'h0 && !single_cycle_flag && exit_state_select == 2'h2
      |=> power_state_status == 2'h2; endproperty
  a_keep: assert property (p_keep) else $error("continuous exit ignored standby");
  property p_chan; conv_start && scan_mode == 2'h0 |-> mux_channel == input_select; endproperty
  a_chan: assert property (p_chan) else $error("wrong channel in mode 1");
  property p_gpo;
    !idle && scan_mode inside {2'h0, 2'h1} && $stable(output_drive_register)
      |=> general_output_pin == $past(output_drive_register); endproperty
  a_gpo: assert property (p_gpo) else $error("outputs not following drive value");
  property p_busy; conv_start |-> power_state_status == 2'h0; endproperty
  a_busy: assert property (p_busy) else $error("start while powered down");
endmodule // seq_sva
bind adc_channel_sequencer seq_sva u_seq_sva (
  .mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .scan_mode(scan_mode),
  .input_select(input_select), .single_cycle_flag(single_cycle_flag),
  .exit_state_select(exit_state_select), .output_drive_register(output_drive_register),
  .power_state_status(power_state_status), .general_output_pin(general_output_pin),
  .mux_channel(mux_channel), .conv_start(conv_start), .autoscan_request(autoscan_request));

// file: tb.sv
// Purpose: mode entry, scan and exit sequences of the sequencer
// Assumes: inputs driven at falling edge, outputs read there
// Notes:   engine latency 10 cycles
`timescale 1ns/100ps
module tb;
  reg        mclk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, ready_clear = 1'b0;
  reg [7:0]  cmd_byte = 8'h00, mux_delay = 8'h00, output_delay = 8'h00;
  reg [1:0]  scan_mode = 2'h0, exit_state_select = 2'h1;
  reg [2:0]  input_select = 3'h3;
  reg        settle_delay_enable = 1'b0, ready_gating = 1'b0, output_settle_delay_enable = 1'b0;
  reg        single_cycle_flag = 1'b0, repeat_single_cycle_flag = 1'b0;
  reg [23:0] channel_table_low = 24'h0, channel_table_high = 24'h0;
  reg [5:0]  output_drive_register = 6'h15;
  wire       conv_done, ready_interrupt_pin, conv_start, autoscan_request, calibration_request;
  wire [1:0] power_state_status;
  wire [5:0] channel_ready_flags, general_output_pin;
  wire [2:0] mux_channel;
  wire [3:0] conv_rate;
  integer    fail_count = 0, n_tests = 0, cycles = 0, n, i;
  reg [2:0]  ch;
  reg        seen;
  adc_channel_sequencer dut (.mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .scan_mode(scan_mode), .input_select(input_select), .settle_delay_enable(settle_delay_enable),
    .ready_gating(ready_gating), .output_settle_delay_enable(output_settle_delay_enable),
    .exit_state_select(exit_state_select), .single_cycle_flag(single_cycle_flag),
    .repeat_single_cycle_flag(repeat_single_cycle_flag), .channel_table_low(channel_table_low),
    .channel_table_high(channel_table_high), .output_drive_register(output_drive_register),
    .mux_delay(mux_delay), .output_delay(output_delay), .conv_done(conv_done),
    .ready_clear(ready_clear), .power_state_status(power_state_status),
    .channel_ready_flags(channel_ready_flags), .general_output_pin(general_output_pin),
    .ready_interrupt_pin(ready_interrupt_pin), .mux_channel(mux_channel), .conv_start(conv_start),
    .autoscan_request(autoscan_request), .calibration_request(calibration_request),
    .conv_rate(conv_rate));
  conv_engine_model eng (.mclk(mclk), .rstn(rstn), .conv_start(conv_start), .conv_done(conv_done));
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      tally_and_finish;
    end
  end
  task check(input [7:0] seen_v, input [7:0] exp_v, input string what);
    begin
      n_tests = n_tests + 1;
      if (seen_v !== exp_v) begin
        fail_count = fail_count + 1;
        $display("mismatch %0s expected %h seen %h", what, exp_v, seen_v);
      end
    end
  endtask
  task send(input [7:0] b);
    begin
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd_byte = b;
      @(negedge mclk);
      cmd_valid = 1'b0;
    end
  endtask
  // bounded waits so a stuck sequencer ends as a mismatch, not a hang
  task wait_start;
    begin
      n = 0;
      do begin @(negedge mclk); n = n + 1; end while (conv_start !== 1'b1 && n < 300);
      check(conv_start, 8'h01, "start seen");
      ch = mux_channel;
    end
  endtask
  task wait_idle;
    begin
      n = 0;
      do begin @(negedge mclk); n = n + 1; end while (power_state_status === 2'h0 && n < 300);
      @(negedge mclk);
    end
  endtask
  task clear_ready;
    begin
      @(negedge mclk);
      ready_clear = 1'b1;
      @(negedge mclk);
      ready_clear = 1'b0;
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    check(power_state_status, 8'h01, "reset status");
    send(8'hB5);
    for (i = 0; i < 3; i = i + 1) begin
      wait_start;
      check(ch, 8'h03, "m1 channel");
    end
    check(conv_rate, 8'h05, "rate");
    output_drive_register = 6'h2A;
    repeat (3) @(negedge mclk);
    check(general_output_pin, 8'h2A, "m1 outputs");
    exit_state_select = 2'h2;
    send(8'h90);
    @(negedge mclk);
    check(power_state_status, 8'h02, "exit standby");
    repeat (12) @(negedge mclk);
    clear_ready;
    input_select = 3'h5;
    single_cycle_flag = 1'b1;
    settle_delay_enable = 1'b1;
    mux_delay = 8'h02;
    send(8'hB0);
    wait_start;
    check(n >= 40 && n <= 48, 8'h01, "mux delay");
    check(ch, 8'h05, "m1 channel5");
    wait_idle;
    check(power_state_status, 8'h01, "single sleep");
    check(ready_interrupt_pin, 8'h01, "ready pin");
    check(channel_ready_flags, 8'h20, "flags m1");
    clear_ready;
    check(channel_ready_flags, 8'h00, "flags clear");
    scan_mode = 2'h1;
    ready_gating = 1'b1;
    repeat_single_cycle_flag = 1'b1;
    settle_delay_enable = 1'b0;
    channel_table_low = 24'h0800FA;
    channel_table_high = 24'h000900;
    send(8'hB0);
    for (i = 0; i < 3; i = i + 1) begin
      wait_start;
      check(ch, (i == 0) ? 8'h02 : (i == 1) ? 8'h04 : 8'h00, "m2 order");
      check(ready_interrupt_pin, 8'h00, "gated ready");
      check(general_output_pin, 8'h2A, "m2 outputs");
    end
    wait_idle;
    check(power_state_status, 8'h01, "m2 sleep");
    check(ready_interrupt_pin, 8'h01, "scan ready");
    check(channel_ready_flags, 8'h15, "flags m2");
    clear_ready;
    scan_mode = 2'h2;
    ready_gating = 1'b0;
    output_settle_delay_enable = 1'b1;
    output_delay = 8'h01;
    channel_table_low = 24'h00C800;
    channel_table_high = 24'h000089;
    send(8'hB0);
    wait_start;
    check(n >= 20, 8'h01, "output delay");
    check(ch, 8'h01, "m3 first");
    check(general_output_pin[4], 8'h01, "m3 bias4");
    wait_start;
    check(ch, 8'h03, "m3 second");
    check(general_output_pin[0], 8'h01, "m3 bias0");
    check(ready_interrupt_pin, 8'h01, "ungated ready");
    wait_idle;
    check(power_state_status, 8'h01, "m3 sleep");
    scan_mode = 2'h3;
    send(8'hC1);
    send(8'h35);
    check(power_state_status, 8'h01, "ignored bytes");
    send(8'hB0);
    @(negedge mclk);
    check(autoscan_request, 8'h01, "autoscan");
    send(8'h90);
    check(autoscan_request, 8'h00, "autoscan exit");
    check(power_state_status, 8'h01, "autoscan sleep");
    scan_mode = 2'h0;
    send(8'hA0);
    seen = calibration_request;
    repeat (3) begin @(negedge mclk); seen = seen | calibration_request; end
    check(seen, 8'h01, "calibration");
    send(8'h80);
    check(power_state_status, 8'h01, "unused mode");
    tally_and_finish;
  end
endmodule // tb
